// ---- verilog/awv_pkg.sv ----
package awv_pkg;
  // Task file offsets
  localparam logic [2:0] REG_DATA        = 3'h0;
  localparam logic [2:0] REG_FEATURE     = 3'h1;
  localparam logic [2:0] REG_COUNT       = 3'h2;
  localparam logic [2:0] REG_SECTOR      = 3'h3;
  localparam logic [2:0] REG_TRACK_LOW   = 3'h4;
  localparam logic [2:0] REG_TRACK_HIGH  = 3'h5;
  localparam logic [2:0] REG_UNIT_HEAD   = 3'h6;
  localparam logic [2:0] REG_COMMAND     = 3'h7;

  // Command codes
  localparam logic [7:0] CMD_WRITE       = 8'h30;
  localparam logic [7:0] CMD_WRITE_NR    = 8'h31;
  localparam logic [7:0] CMD_WRITE_NOERS = 8'h38;
  localparam logic [7:0] CMD_WRITE_VFY   = 8'h3C;

  // Status bit positions
  localparam int STS_BSY  = 7;
  localparam int STS_DRDY = 6;
  localparam int STS_DSC  = 4;
  localparam int STS_DRQ  = 3;
  localparam int STS_ERR  = 0;

  // Error register bit positions
  localparam int ERRB_MEDIA = 6;
  localparam int ERRB_ABRT  = 2;

  // Unit/head field
  localparam int UH_LBA = 6;

  // Reset values, and the sector total loaded for a count of zero
  localparam logic [7:0] RST_TASK      = 8'h00;
  localparam logic [7:0] RST_UNIT_HEAD = 8'hA0;
  localparam logic [8:0] FULL_COUNT    = 9'h100;

  // Sector payload in 16-bit data words
  localparam logic [7:0] LAST_WORD     = 8'hFF;

  // Media operation codes
  typedef enum logic [1:0] {
    MOP_ERASE,
    MOP_PROGRAM,
    MOP_VERIFY
  } awv_mop_e;
endpackage

// ---- verilog/awv_sector_seq.sv ----
`timescale 1ns/1ns
module awv_sector_seq (
  input  wire logic              i_clock,
  input  wire logic              i_reset_n,
  input  wire logic              i_start,
  input  wire logic              i_skip_erase,
  input  wire logic              i_verify,
  input  wire logic              i_erased,
  input  wire logic              i_media_done,
  input  wire logic              i_media_fail,
  output awv_pkg::awv_mop_e      o_op,
  output logic                   o_go,
  output logic                   o_done,
  output logic                   o_fail
);
  typedef enum logic [1:0] {
    SQ_IDLE,
    SQ_ERASE,
    SQ_PROG,
    SQ_VER
  } awv_sq_e;

  awv_sq_e state;

  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      state  <= SQ_IDLE;
      o_op   <= awv_pkg::MOP_ERASE;
      o_go   <= 1'b0;
      o_done <= 1'b0;
      o_fail <= 1'b0;
    end else begin
      o_go   <= 1'b0;
      o_done <= 1'b0;
      o_fail <= 1'b0;
      case (state)
        SQ_IDLE: begin
          if (i_start) begin
            o_go <= 1'b1;
            if (i_skip_erase && i_erased) begin
              state <= SQ_PROG;
              o_op  <= awv_pkg::MOP_PROGRAM;
            end else begin
              state <= SQ_ERASE;
              o_op  <= awv_pkg::MOP_ERASE;
            end
          end
        end
        SQ_ERASE: begin
          if (i_media_fail) begin
            state  <= SQ_IDLE;
            o_fail <= 1'b1;
          end else if (i_media_done) begin
            state <= SQ_PROG;
            o_op  <= awv_pkg::MOP_PROGRAM;
            o_go  <= 1'b1;
          end
        end
        SQ_PROG: begin
          if (i_media_fail) begin
            state  <= SQ_IDLE;
            o_fail <= 1'b1;
          end else if (i_media_done && i_verify) begin
            state <= SQ_VER;
            o_op  <= awv_pkg::MOP_VERIFY;
            o_go  <= 1'b1;
          end else if (i_media_done) begin
            state  <= SQ_IDLE;
            o_done <= 1'b1;
          end
        end
        SQ_VER: begin
          if (i_media_fail) begin
            state  <= SQ_IDLE;
            o_fail <= 1'b1;
          end else if (i_media_done) begin
            state  <= SQ_IDLE;
            o_done <= 1'b1;
          end
        end
        default: state <= SQ_IDLE;
      endcase
    end
  end
endmodule

// ---- verilog/awv_top.sv ----
`timescale 1ns/1ns
module awv_top (
  input  wire logic        I_CLOCK,
  input  wire logic        I_RESET_N,
  input  wire logic        I_REG_WE,
  input  wire logic        I_REG_RE,
  input  wire logic [2:0]  I_REG_ADDR,
  input  wire logic [7:0]  I_REG_WDATA,
  input  wire logic        I_DATA_WE,
  input  wire logic [15:0] I_DATA,
  input  wire logic        I_MEDIA_DONE,
  input  wire logic        I_MEDIA_FAIL,
  input  wire logic        I_MEDIA_ERASED,
  output logic [7:0]       O_REG_RDATA,
  output logic             O_BSY,
  output logic             O_DRQ,
  output logic             O_INTRQ,
  output logic [15:0]      O_MEDIA_WDATA,
  output logic             O_MEDIA_WVALID,
  output logic             O_MEDIA_GO,
  output logic [1:0]       O_MEDIA_OP,
  output logic [27:0]      O_MEDIA_LBA
);
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_ACCEPT,
    ST_XFER,
    ST_EXEC
  } awv_st_e;

  awv_st_e           state;
  logic [7:0]        feature;
  logic [7:0]        count;
  logic [7:0]        sector;
  logic [7:0]        track_low;
  logic [7:0]        track_high;
  logic [7:0]        unit_head;
  logic [7:0]        error_bits;
  logic              err_flag;
  logic [8:0]        remaining;
  logic [7:0]        word_idx;
  logic              skip_erase;
  logic              verify;
  logic              seq_start;
  logic              seq_go;
  logic              seq_done;
  logic              seq_fail;
  awv_pkg::awv_mop_e seq_op;
  logic [27:0]       cur_addr;
  logic [27:0]       next_addr;
  logic [7:0]        status;
  logic              cmd_wr;
  logic              is_write;
  logic              task_wr;

  function automatic logic is_write_cmd(input logic [7:0] c);
    is_write_cmd = (c == awv_pkg::CMD_WRITE) ||
                   (c == awv_pkg::CMD_WRITE_NR) ||
                   (c == awv_pkg::CMD_WRITE_NOERS) ||
                   (c == awv_pkg::CMD_WRITE_VFY);
  endfunction

  // CHS mode uses the same packing; no geometry translation is done here
  assign cur_addr  = {unit_head[3:0], track_high, track_low, sector};
  assign next_addr = cur_addr + 28'h0000001;
  assign cmd_wr    = I_REG_WE && (I_REG_ADDR == awv_pkg::REG_COMMAND);
  assign is_write  = is_write_cmd(I_REG_WDATA);
  // Task file is frozen while a command runs so the host cannot race it
  assign task_wr   = I_REG_WE && (state == ST_IDLE);

  always_comb begin
    status = 8'h00;
    status[awv_pkg::STS_BSY]  = O_BSY;
    status[awv_pkg::STS_DRDY] = !O_BSY;
    status[awv_pkg::STS_DSC]  = !O_BSY;
    status[awv_pkg::STS_DRQ]  = O_DRQ;
    status[awv_pkg::STS_ERR]  = err_flag;
  end

  always_ff @(posedge I_CLOCK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      state      <= ST_IDLE;
      O_BSY      <= 1'b0;
      O_DRQ      <= 1'b0;
      remaining  <= 9'h000;
      word_idx   <= 8'h00;
      skip_erase <= 1'b0;
      verify     <= 1'b0;
      seq_start  <= 1'b0;
    end else begin
      seq_start <= 1'b0;
      case (state)
        ST_IDLE: begin
          if (cmd_wr && is_write) begin
            state      <= ST_ACCEPT;
            O_BSY      <= 1'b1;
            skip_erase <= (I_REG_WDATA == awv_pkg::CMD_WRITE_NOERS);
            verify     <= (I_REG_WDATA == awv_pkg::CMD_WRITE_VFY);
            remaining  <= (count == 8'h00) ? awv_pkg::FULL_COUNT :
                          {1'b0, count};
          end
        end
        ST_ACCEPT: begin
          state    <= ST_XFER;
          O_BSY    <= 1'b0;
          O_DRQ    <= 1'b1;
          word_idx <= 8'h00;
        end
        ST_XFER: begin
          if (I_DATA_WE) begin
            word_idx <= word_idx + 8'h01;
            if (word_idx == awv_pkg::LAST_WORD) begin
              state     <= ST_EXEC;
              O_BSY     <= 1'b1;
              O_DRQ     <= 1'b0;
              seq_start <= 1'b1;
            end
          end
        end
        ST_EXEC: begin
          if (seq_fail) begin
            state <= ST_IDLE;
            O_BSY <= 1'b0;
          end else if (seq_done) begin
            remaining <= remaining - 9'h001;
            if (remaining == 9'h001) begin
              state <= ST_IDLE;
              O_BSY <= 1'b0;
            end else begin
              state    <= ST_XFER;
              O_BSY    <= 1'b0;
              O_DRQ    <= 1'b1;
              word_idx <= 8'h00;
            end
          end
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

  // Interrupt: set on data request for later sectors and on completion
  always_ff @(posedge I_CLOCK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      O_INTRQ <= 1'b0;
    end else if (state == ST_EXEC && (seq_fail || seq_done)) begin
      O_INTRQ <= 1'b1;
    end else if (state == ST_IDLE && cmd_wr && !is_write) begin
      O_INTRQ <= 1'b1;
    end else if (cmd_wr ||
                 (I_REG_RE && I_REG_ADDR == awv_pkg::REG_COMMAND)) begin
      O_INTRQ <= 1'b0;
    end
  end

  // Error reporting; unknown commands are aborted
  always_ff @(posedge I_CLOCK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      err_flag   <= 1'b0;
      error_bits <= awv_pkg::RST_TASK;
    end else if (state == ST_EXEC && seq_fail) begin
      err_flag                       <= 1'b1;
      error_bits                     <= awv_pkg::RST_TASK;
      error_bits[awv_pkg::ERRB_MEDIA] <= 1'b1;
    end else if (state == ST_IDLE && cmd_wr) begin
      err_flag                       <= !is_write;
      error_bits                     <= awv_pkg::RST_TASK;
      error_bits[awv_pkg::ERRB_ABRT]  <= !is_write;
    end
  end

  // Task file; address and residual count advance only after a good sector
  always_ff @(posedge I_CLOCK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      feature    <= awv_pkg::RST_TASK;
      count      <= awv_pkg::RST_TASK;
      sector     <= awv_pkg::RST_TASK;
      track_low  <= awv_pkg::RST_TASK;
      track_high <= awv_pkg::RST_TASK;
      unit_head  <= awv_pkg::RST_UNIT_HEAD;
    end else if (state == ST_EXEC && seq_done) begin
      count      <= count - 8'h01;
      if (remaining != 9'h001) begin
        sector     <= next_addr[7:0];
        track_low  <= next_addr[15:8];
        track_high <= next_addr[23:16];
        unit_head  <= {unit_head[7:4], next_addr[27:24]};
      end
    end else if (task_wr) begin
      case (I_REG_ADDR)
        awv_pkg::REG_FEATURE:    feature    <= I_REG_WDATA;
        awv_pkg::REG_COUNT:      count      <= I_REG_WDATA;
        awv_pkg::REG_SECTOR:     sector     <= I_REG_WDATA;
        awv_pkg::REG_TRACK_LOW:  track_low  <= I_REG_WDATA;
        awv_pkg::REG_TRACK_HIGH: track_high <= I_REG_WDATA;
        awv_pkg::REG_UNIT_HEAD:  unit_head  <= I_REG_WDATA;
        default:                 feature    <= feature;
      endcase
    end
  end

  // Registered read port; offset 1 reads error, offset 7 reads status
  always_ff @(posedge I_CLOCK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      O_REG_RDATA <= awv_pkg::RST_TASK;
    end else if (I_REG_RE) begin
      case (I_REG_ADDR)
        awv_pkg::REG_FEATURE:    O_REG_RDATA <= error_bits;
        awv_pkg::REG_COUNT:      O_REG_RDATA <= count;
        awv_pkg::REG_SECTOR:     O_REG_RDATA <= sector;
        awv_pkg::REG_TRACK_LOW:  O_REG_RDATA <= track_low;
        awv_pkg::REG_TRACK_HIGH: O_REG_RDATA <= track_high;
        awv_pkg::REG_UNIT_HEAD:  O_REG_RDATA <= unit_head;
        awv_pkg::REG_COMMAND:    O_REG_RDATA <= status;
        default:                 O_REG_RDATA <= awv_pkg::RST_TASK;
      endcase
    end
  end

  // Media side: data words pass straight through, no sector buffer
  always_ff @(posedge I_CLOCK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      O_MEDIA_WDATA  <= 16'h0000;
      O_MEDIA_WVALID <= 1'b0;
      O_MEDIA_GO     <= 1'b0;
      O_MEDIA_OP     <= 2'h0;
      O_MEDIA_LBA    <= 28'h0000000;
    end else begin
      O_MEDIA_WVALID <= (state == ST_XFER) && I_DATA_WE;
      if ((state == ST_XFER) && I_DATA_WE) begin
        O_MEDIA_WDATA <= I_DATA;
      end
      O_MEDIA_GO  <= seq_go;
      O_MEDIA_OP  <= seq_op;
      O_MEDIA_LBA <= cur_addr;
    end
  end

  awv_sector_seq u_seq (
    .i_clock      (I_CLOCK),
    .i_reset_n    (I_RESET_N),
    .i_start      (seq_start),
    .i_skip_erase (skip_erase),
    .i_verify     (verify),
    .i_erased     (I_MEDIA_ERASED),
    .i_media_done (I_MEDIA_DONE),
    .i_media_fail (I_MEDIA_FAIL),
    .o_op         (seq_op),
    .o_go         (seq_go),
    .o_done       (seq_done),
    .o_fail       (seq_fail)
  );
endmodule

// ---- tb/awv_top_sva.sv ----
`timescale 1ns/1ns
module awv_top_sva (
  input  wire logic        I_CLOCK,
  input  wire logic        I_RESET_N,
  input  wire logic        I_REG_WE,
  input  wire logic        I_REG_RE,
  input  wire logic [2:0]  I_REG_ADDR,
  input  wire logic [7:0]  I_REG_WDATA,
  input  wire logic        I_DATA_WE,
  input  wire logic [15:0] I_DATA,
  input  wire logic        I_MEDIA_DONE,
  input  wire logic        I_MEDIA_FAIL,
  input  wire logic        I_MEDIA_ERASED,
  input  wire logic        O_BSY,
  input  wire logic        O_DRQ,
  input  wire logic        O_INTRQ,
  input  wire logic [15:0] O_MEDIA_WDATA,
  input  wire logic        O_MEDIA_WVALID,
  input  wire logic        O_MEDIA_GO,
  input  wire logic [1:0]  O_MEDIA_OP
);
  logic [7:0] wcnt;
  logic [7:0] cmd_q;
  logic       pend;
  logic [1:0] last_op;
  logic       first;
  logic       idle;
  logic       last_word;
  logic       cmd_acc;
  assign idle = !O_BSY && !O_DRQ;
  assign last_word = O_DRQ && I_DATA_WE && wcnt == 8'hFF;
  assign cmd_acc = I_REG_WE && I_REG_ADDR == awv_pkg::REG_COMMAND;
  // Words of the current sector; cleared whenever the data phase closes
  always_ff @(posedge I_CLOCK or negedge I_RESET_N) begin
    if (!I_RESET_N) wcnt <= 8'h00;
    else if (!O_DRQ) wcnt <= 8'h00;
    else if (I_DATA_WE) wcnt <= wcnt + 8'h01;
  end
  always_ff @(posedge I_CLOCK or negedge I_RESET_N) begin
    if (!I_RESET_N) cmd_q <= 8'h00;
    else if (cmd_acc && idle) cmd_q <= I_REG_WDATA;
  end
  always_ff @(posedge I_CLOCK or negedge I_RESET_N) begin
    if (!I_RESET_N) pend <= 1'b0;
    else if (O_MEDIA_GO) pend <= 1'b1;
    else if (I_MEDIA_DONE || I_MEDIA_FAIL) pend <= 1'b0;
  end
  always_ff @(posedge I_CLOCK or negedge I_RESET_N) begin
    if (!I_RESET_N) last_op <= 2'h0;
    else if (O_MEDIA_GO) last_op <= O_MEDIA_OP;
  end
  always_ff @(posedge I_CLOCK or negedge I_RESET_N) begin
    if (!I_RESET_N) first <= 1'b0;
    else if (last_word) first <= 1'b1;
    else if (O_MEDIA_GO) first <= 1'b0;
  end
  default clocking @(posedge I_CLOCK); endclocking
  default disable iff (!I_RESET_N);
  property p_accept;
    cmd_acc && idle && I_REG_WDATA inside {8'h30, 8'h31, 8'h38, 8'h3C}
      |=> O_BSY ##1 (!O_BSY && O_DRQ && !O_INTRQ);
  endproperty
  a_accept: assert property (p_accept) else $error("bad accept");
  property p_last_word;
    last_word |=> (O_BSY && !O_DRQ) ##2 O_MEDIA_GO;
  endproperty
  a_last_word: assert property (p_last_word) else $error("bad end");
  property p_forward;
    I_DATA_WE && O_DRQ |=> O_MEDIA_WVALID && O_MEDIA_WDATA == $past(I_DATA);
  endproperty
  a_forward: assert property (p_forward) else $error("bad word");
  property p_first_op;
    O_MEDIA_GO && first |-> O_MEDIA_OP == ((cmd_q == awv_pkg::CMD_WRITE_NOERS
      && I_MEDIA_ERASED) ? 2'h1 : 2'h0);
  endproperty
  a_first_op: assert property (p_first_op) else $error("bad op");
  property p_erase_prog;
    I_MEDIA_DONE && pend && last_op == 2'h0
      |-> ##2 (O_MEDIA_GO && O_MEDIA_OP == 2'h1);
  endproperty
  a_erase_prog: assert property (p_erase_prog) else $error("no prog");
  property p_prog_vfy;
    I_MEDIA_DONE && pend && last_op == 2'h1 && cmd_q == awv_pkg::CMD_WRITE_VFY
      |-> ##[1:3] (O_MEDIA_GO && O_MEDIA_OP == 2'h2);
  endproperty
  a_prog_vfy: assert property (p_prog_vfy) else $error("no check");
  property p_fail;
    I_MEDIA_FAIL && pend |-> ##[1:3] (!O_BSY && !O_DRQ && O_INTRQ);
  endproperty
  a_fail: assert property (p_fail) else $error("bad fail end");
  property p_intrq;
    O_INTRQ && !((I_REG_RE || I_REG_WE) && I_REG_ADDR == awv_pkg::REG_COMMAND)
      |=> O_INTRQ;
  endproperty
  a_intrq: assert property (p_intrq) else $error("intrq lost");
  property p_go_busy;
    O_MEDIA_GO |-> O_BSY && !O_DRQ;
  endproperty
  a_go_busy: assert property (p_go_busy) else $error("go not busy");
  c_noerase: cover property (O_MEDIA_GO && first && O_MEDIA_OP == 2'h1);
  c_verify: cover property (O_MEDIA_GO && O_MEDIA_OP == 2'h2);
  c_fail: cover property (I_MEDIA_FAIL && pend);
endmodule

// ---- tb/awv_media_model.sv ----
`timescale 1ns/1ns
module awv_media_model (
  input  wire logic        i_clock,
  input  wire logic        i_reset_n,
  input  wire logic        i_go,
  input  wire logic [1:0]  i_op,
  input  wire logic [27:0] i_lba,
  input  wire logic [3:0]  i_lat,
  input  wire logic [27:0] i_fail_lba,
  input  wire logic [1:0]  i_fail_op,
  input  wire logic        i_clear,
  output logic             o_done,
  output logic             o_fail,
  output logic [7:0]       o_trace
);
  logic [3:0] wait_cnt;
  logic       busy;
  logic       bad;
  // Latency is per operation, so slow and prompt media both get exercised
  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      busy <= 1'b0;
      bad <= 1'b0;
      wait_cnt <= 4'h0;
      o_done <= 1'b0;
      o_fail <= 1'b0;
    end else begin
      o_done <= 1'b0;
      o_fail <= 1'b0;
      if (i_go) begin
        busy <= 1'b1;
        wait_cnt <= i_lat;
        bad <= i_lba == i_fail_lba && i_op == i_fail_op;
      end else if (busy && wait_cnt == 4'h0) begin
        busy <= 1'b0;
        o_done <= !bad;
        o_fail <= bad;
      end else if (busy) wait_cnt <= wait_cnt - 4'h1;
    end
  end
  // Last four operations, newest in the low bits
  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) o_trace <= 8'hFF;
    else if (i_clear) o_trace <= 8'hFF;
    else if (i_go) o_trace <= {o_trace[5:0], i_op};
  end
endmodule

// ---- tb/awv_top_test.sv ----
`timescale 1ns/1ns
module awv_top_test;
  logic clk = 1'b0, rst_n = 1'b0, we = 1'b0, re = 1'b0, dwe = 1'b0;
  logic [2:0] addr = 3'h0;
  logic [7:0] wdata = 8'h00, rdata, rv, trace;
  logic [15:0] dat = 16'h0000, mwdata;
  logic done, fail, erased = 1'b1, bsy, drq, intrq, mwvalid, go, clr = 1'b0;
  logic [1:0] op, fop = 2'h3;
  logic [27:0] lba, flba = 28'hFFFFFFF;
  logic [3:0] lat = 4'h0;
  int error_cnt = 0, n_tests = 0, cyc = 0, e;
  always #5 clk = ~clk;
  awv_top awv_top_inst (.I_CLOCK(clk), .I_RESET_N(rst_n), .I_REG_WE(we),
    .I_REG_RE(re), .I_REG_ADDR(addr), .I_REG_WDATA(wdata), .I_DATA_WE(dwe),
    .I_DATA(dat), .I_MEDIA_DONE(done), .I_MEDIA_FAIL(fail),
    .I_MEDIA_ERASED(erased), .O_REG_RDATA(rdata), .O_BSY(bsy), .O_DRQ(drq),
    .O_INTRQ(intrq), .O_MEDIA_WDATA(mwdata), .O_MEDIA_WVALID(mwvalid),
    .O_MEDIA_GO(go), .O_MEDIA_OP(op), .O_MEDIA_LBA(lba));
  awv_media_model awv_media_model_inst (.i_clock(clk), .i_reset_n(rst_n),
    .i_go(go), .i_op(op), .i_lba(lba), .i_lat(lat), .i_fail_lba(flba),
    .i_fail_op(fop), .i_clear(clr), .o_done(done), .o_fail(fail),
    .o_trace(trace));
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] x,
                     input logic [31:0] g);
    n_tests++;
    if (g !== x) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", nm, x, g);
    end
  endtask
  task automatic tick;
    @(posedge clk);
    #1;
  endtask
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    addr = a; wdata = d; we = 1'b1; tick; we = 1'b0; tick;
  endtask
  task automatic rd(input logic [2:0] a, output logic [7:0] d);
    addr = a; re = 1'b1; tick; re = 1'b0; tick; d = rdata;
  endtask
  // Bounded wait: for data request, or for the end of the command
  task automatic wait_st(input logic want_drq);
    int i;
    for (i = 0; i < 500 && !(want_drq ? drq === 1'b1
         : (bsy === 1'b0 && intrq === 1'b1)); i++) tick;
    chk("wait state", 1, want_drq ? drq : (!bsy && intrq));
  endtask
  task automatic sector;
    int i;
    dwe = 1'b1;
    for (i = 0; i < 256; i++) begin
      dat = 16'h5A00 + i[15:0];
      tick;
    end
    dwe = 1'b0;
  endtask
  task automatic run(input logic [7:0] code, input logic [7:0] cnt,
                     input logic [27:0] a, input int nsec);
    int s;
    clr = 1'b1; tick; clr = 1'b0;
    wr(3'h2, cnt); wr(3'h3, a[7:0]); wr(3'h4, a[15:8]); wr(3'h5, a[23:16]);
    wr(3'h6, {4'hE, a[27:24]}); wr(3'h7, code);
    chk("accept status", 3'b010, {bsy, drq, intrq});
    for (s = 0; s < nsec; s++) begin
      wait_st(1'b1);
      if (s > 0) chk("sector intrq", 1, intrq);
      sector;
    end
    wait_st(1'b0);
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      error_cnt++;
      report_and_stop;
    end
  end
  initial begin
    repeat (12) @(posedge clk);
    #1 rst_n = 1'b1;
    rd(3'h6, rv); chk("unit head reset", 8'hA0, rv);
    rd(3'h7, rv); chk("status reset", 8'h50, rv);
    $display("reset test done");
    run(8'h30, 8'h01, 28'h1234567, 1);
    chk("plain ops", 8'hF1, trace);
    chk("media address", 28'h1234567, lba);
    rd(3'h3, rv); chk("sector index", 8'h67, rv);
    rd(3'h5, rv); chk("track high", 8'h23, rv);
    rd(3'h2, rv); chk("count done", 8'h00, rv);
    rd(3'h7, rv); chk("status done", 8'h50, rv);
    chk("intrq cleared", 0, intrq);
    chk("last media word", 16'h5AFF, mwdata);
    chk("media valid idle", 0, mwvalid);
    $display("plain write test done");
    // Pre-erased target first, then one that was never erased
    for (e = 1; e >= 0; e--) begin
      erased = e[0];
      run(8'h38, 8'h01, 28'h0000100, 1);
      chk("no erase ops", e ? 8'hFD : 8'hF1, trace);
      rd(3'h7, rv);
      chk("no erase status", 8'h50, rv);
    end
    $display("no erase test done");
    run(8'h3C, 8'h02, 28'h0000010, 2);
    chk("verify ops", 8'h86, trace);
    chk("last address", 28'h0000011, lba);
    rd(3'h2, rv); chk("verify count", 8'h00, rv);
    $display("verify test done");
    flba = 28'h0000021; fop = 2'h2;
    run(8'h3C, 8'h03, 28'h0000020, 2);
    rd(3'h7, rv); chk("fail status", 8'h51, rv);
    rd(3'h1, rv); chk("fail error", 8'h40, rv);
    rd(3'h3, rv); chk("fail sector", 8'h21, rv);
    rd(3'h2, rv); chk("fail residual", 8'h02, rv);
    $display("verify fail test done");
    // A code outside the write family must abort, not start a transfer
    wr(3'h7, 8'hEE);
    chk("abort intrq", 1, intrq);
    rd(3'h1, rv);
    chk("abort error", 8'h04, rv);
    rd(3'h7, rv);
    chk("abort status", 8'h51, rv);
    $display("abort test done");
    flba = 28'h0000041; fop = 2'h1; lat = 4'h7;
    run(8'h31, 8'h00, 28'h0000040, 2);
    rd(3'h2, rv); chk("full residual", 8'hFF, rv);
    rd(3'h3, rv); chk("full sector", 8'h41, rv);
    $display("full count test done");
    report_and_stop;
  end
endmodule
bind awv_top awv_top_sva awv_top_sva_inst (.I_CLOCK(I_CLOCK),
  .I_RESET_N(I_RESET_N), .I_REG_WE(I_REG_WE), .I_REG_RE(I_REG_RE),
  .I_REG_ADDR(I_REG_ADDR), .I_REG_WDATA(I_REG_WDATA), .I_DATA_WE(I_DATA_WE),
  .I_DATA(I_DATA), .I_MEDIA_DONE(I_MEDIA_DONE), .I_MEDIA_FAIL(I_MEDIA_FAIL),
  .I_MEDIA_ERASED(I_MEDIA_ERASED), .O_BSY(O_BSY), .O_DRQ(O_DRQ),
  .O_INTRQ(O_INTRQ), .O_MEDIA_WDATA(O_MEDIA_WDATA),
  .O_MEDIA_WVALID(O_MEDIA_WVALID), .O_MEDIA_GO(O_MEDIA_GO),
  .O_MEDIA_OP(O_MEDIA_OP));
